//--- test/power_clock_manager_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module power_clock_manager_regs_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic enabled_irq,
  input wire logic cpu_clock_enable,
  input wire logic [5:0] timer_ch_clock,
  input wire logic io_port_a_clock,
  input wire logic pll_enable,
  input wire logic [10:0] pll_multiplier,
  input wire logic pll_range_select,
  input wire logic pll_bypass,
  input wire logic pll_lock_irq,
  input wire logic clock_out_pin_oe
);
  // ==========================================================
  // Data phase tracking
  logic dp_wr; // Write data phase pending
  logic [7:0] dp_a; // Offset of that write
  logic fixed; // Range bit already written once
  logic wr_now; // Write data is on the bus this cycle
  assign wr_now = dp_wr && hready;

  // Capture address phase of each write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_a <= 8'h00;
    end else if (hready) begin
      dp_wr <= hsel && htrans == 2'h2 && hwrite;
      dp_a <= haddr[7:0];
    end
  end

  // Note the first mode write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fixed <= 1'b0;
    end else if (wr_now && dp_a == 8'h20) begin
      fixed <= 1'b1;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_sys_off;
    wr_now && dp_a == 8'h04 && hwdata[0] && !enabled_irq
      |=> !cpu_clock_enable;
  endproperty
  a_sys_off: assert property (p_sys_off) else $error("cpu clock kept");

  property p_wake;
    enabled_irq |=> cpu_clock_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_per_on;
    wr_now && dp_a == 8'h10 && hwdata[6] |=> timer_ch_clock[0];
  endproperty
  a_per_on: assert property (p_per_on) else $error("timer on");

  property p_per_off;
    wr_now && dp_a == 8'h14 && hwdata[13] |=> !io_port_a_clock;
  endproperty
  a_per_off: assert property (p_per_off) else $error("port off");

  property p_pll_en;
    pll_enable == (pll_multiplier != 11'h000) && (pll_enable || pll_bypass);
  endproperty
  a_pll_en: assert property (p_pll_en) else $error("pll enable");

  property p_relock;
    wr_now && dp_a == 8'h20 && hwdata[18:8] != pll_multiplier
      && hwdata[18:8] != 11'h000 |-> ##[1:2] pll_bypass;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock");

  property p_lock_bp;
    pll_lock_irq |-> !pll_bypass;
  endproperty
  a_lock_bp: assert property (p_lock_bp) else $error("bypass");

  property p_oe;
    wr_now && dp_a == 8'h20
      |=> clock_out_pin_oe == !$past(hwdata[6]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");

  property p_range;
    fixed |=> $stable(pll_range_select);
  endproperty
  a_range: assert property (p_range) else $error("range moved");

  property p_rd_wait;
    hsel && hready && htrans == 2'h2 && !hwrite
      |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
endmodule

bind power_clock_manager_regs power_clock_manager_regs_chk i_chk (.*);

`default_nettype wire

//--- test/power_clock_manager_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module power_clock_manager_regs_tb;
  // ==========================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rd, pv;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic slow_clock, pll_tick, enabled_irq, cpu_clock_enable;
  logic serial_port0_clock, serial_port1_clock, io_port_b_clock;
  logic sync_serial_a_clock, sync_serial_b_clock, io_port_a_clock;
  logic [5:0] timer_ch_clock;
  logic [10:0] pll_multiplier;
  logic pll_enable, pll_range_select, pll_bypass, pll_lock_irq;
  logic master_clock, clock_out_pin, clock_out_pin_oe;
  int fails, num_checks;
  int rises = 0; // Rising edges seen on the output pin
  logic pin_q; // Output pin level at the last edge

  power_clock_manager_regs i_power_clock_manager_regs (.*);
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  // Peripheral gates laid out like the status word
  assign pv = {17'h0, io_port_b_clock, io_port_a_clock, 1'b0,
    timer_ch_clock, sync_serial_b_clock, sync_serial_a_clock,
    serial_port1_clock, serial_port0_clock, 2'b00};
  // Count rising edges of the clock output pin
  always @(posedge hclk) begin
    pin_q <= clock_out_pin;
    if (clock_out_pin && !pin_q) begin
      rises <= rises + 1;
    end
  end

  // ==========================================================
  // Clock, compare and closing
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask

  task stop_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus cycles: address phase, then data phase, one word
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    @(negedge hclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // Whole slow clock periods, each with one rising edge
  task slow(input int n);
    repeat (n) begin
      @(posedge hclk);
      slow_clock <= 1'b1;
      repeat (8) @(posedge hclk);
      slow_clock <= 1'b0;
      repeat (8) @(posedge hclk);
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    rdchk("sys", 8'h08, 32'h1);
    rdchk("pst", 8'h1c, 32'h0);
    rdchk("mode", 8'h20, 32'h0);
    rdchk("lock", 8'h30, 32'h0);
    rdchk("hole", 8'h0c, 32'h0);
    chkb("byp", 1'b1, pll_bypass);
    chkb("oe", 1'b1, clock_out_pin_oe);
  endtask

  task t_sys;
    wr(8'h04, 32'h0);
    rdchk("sys0", 8'h08, 32'h1);
    wr(8'h04, 32'h1);
    chkb("cpu", 1'b0, cpu_clock_enable);
    rdchk("sys1", 8'h08, 32'h0);
    @(posedge hclk);
    enabled_irq <= 1'b1;
    @(posedge hclk);
    enabled_irq <= 1'b0;
    rdchk("wake", 8'h08, 32'h1);
  endtask

  task t_per;
    int b;
    logic [31:0] e;
    e = 32'h0;
    // One bit at a time, unused bits included
    for (b = 0; b < 16; b++) begin
      e = e | ((32'h1 << b) & 32'h0000_6ffc);
      wr(8'h10, 32'h1 << b);
      rdchk("pen", 8'h1c, e);
      chk("pout", e, pv);
    end
    for (b = 15; b >= 0; b--) begin
      e = e & ~(32'h1 << b);
      wr(8'h14, 32'h1 << b);
      rdchk("pdis", 8'h1c, e);
      chk("pout", e, pv);
    end
  endtask

  task t_mode;
    int s;
    int l;
    // Range high, multiplier 5, lock count 3
    wr(8'h20, 32'h0300_0508);
    chkb("pen", 1'b1, pll_enable);
    chkb("rng", 1'b1, pll_range_select);
    chk("mul", 32'h5, {21'h0, pll_multiplier});
    chkb("byp", 1'b1, pll_bypass);
    slow(2);
    rdchk("lk0", 8'h30, 32'h0);
    slow(1);
    rdchk("lk1", 8'h30, 32'h1);
    chkb("byp1", 1'b0, pll_bypass);
    chkb("irq0", 1'b0, pll_lock_irq);
    wr(8'h34, 32'h0);
    chkb("irq1", 1'b0, pll_lock_irq);
    wr(8'h34, 32'h1);
    chkb("irq2", 1'b1, pll_lock_irq);
    wr(8'h38, 32'h0);
    chkb("irq3", 1'b1, pll_lock_irq);
    wr(8'h38, 32'h1);
    chkb("irq4", 1'b0, pll_lock_irq);
    // New multiplier, range low refused
    wr(8'h20, 32'h0300_0600);
    rdchk("lk2", 8'h30, 32'h0);
    rdchk("md", 8'h20, 32'h0300_0608);
    wr(8'h20, 32'h0300_0648);
    repeat (2) @(negedge hclk);
    chkb("oe0", 1'b0, clock_out_pin_oe);
    // Output source against a steady slow clock level
    for (l = 0; l < 2; l++) begin
      @(posedge hclk);
      slow_clock <= l[0];
      for (s = 0; s < 3; s++) begin
        wr(8'h20, 32'h0300_0608 | (s << 4));
        repeat (10) @(negedge hclk);
        chkb("oe1", 1'b1, clock_out_pin_oe);
        chkb("out", l[0] ^ (s == 2), clock_out_pin);
      end
    end
    wr(8'h20, 32'h0000_0008);
    chkb("pen0", 1'b0, pll_enable);
  endtask

  // Prescaler codes, halved output and PLL source, counted at the pin
  task t_div;
    int c;
    int r0;
    for (c = 0; c < 5; c++) begin
      // Codes 0..3 on the master output; pass 4 picks master halved
      wr(8'h20, c < 4 ? 32'h0300_0518 | c : 32'h0300_0538);
      slow(1);
      r0 = rises;
      slow(8);
      chk("div", c < 4 ? 32'h8 >> c : 32'h4, rises - r0);
    end
    // Locked PLL as source: sixteen ticks give eight rising edges
    wr(8'h20, 32'h0300_0598);
    repeat (3) @(posedge hclk);
    r0 = rises;
    repeat (16) begin
      @(posedge hclk);
      pll_tick <= 1'b1;
      @(posedge hclk);
      pll_tick <= 1'b0;
    end
    repeat (4) @(posedge hclk);
    chk("pll", 32'h8, rises - r0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    slow_clock = 1'b0;
    pll_tick = 1'b0;
    enabled_irq = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_sys;
    t_per;
    t_mode;
    t_div;
    stop_test;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    stop_test;
  end
endmodule

`default_nettype wire

//--- verilog/clock_manager_pkg.sv
package clock_manager_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] off_system_clock_disable = 8'h04;
  localparam logic [7:0] off_system_clock_status = 8'h08;
  localparam logic [7:0] off_periph_clock_enable = 8'h10;
  localparam logic [7:0] off_periph_clock_disable = 8'h14;
  localparam logic [7:0] off_periph_clock_status = 8'h1c;
  localparam logic [7:0] off_clock_generator_mode = 8'h20;
  localparam logic [7:0] off_pll_lock_status = 8'h30;
  localparam logic [7:0] off_pll_irq_enable = 8'h34;
  localparam logic [7:0] off_pll_irq_disable = 8'h38;
  localparam int addr_width = 8;

  // ==========================================================
  // Reset values
  localparam logic [31:0] system_clock_status_reset = 32'h0000_0001;
  localparam logic [31:0] periph_clock_status_reset = 32'h0000_0000;
  localparam logic [31:0] clock_generator_mode_reset = 32'h0000_0000;

  // ==========================================================
  // Single-bit flags at bit 0
  localparam int cpu_bit = 0;
  localparam int lock_bit = 0;

  // ==========================================================
  // Peripheral clock bit map
  localparam int serial_port0_bit = 2;
  localparam int serial_port1_bit = 3;
  localparam int sync_serial_a_bit = 4;
  localparam int sync_serial_b_bit = 5;
  localparam int timer_ch0_bit = 6;
  localparam int timer_ch5_bit = 11;
  localparam int io_port_a_bit = 13;
  localparam int io_port_b_bit = 14;
  localparam logic [15:0] periph_valid_mask = 16'h6ffc;

  // ==========================================================
  // Clock generator mode field positions
  localparam int divider_select_lsb = 0;
  localparam int divider_select_msb = 2;
  localparam int pll_range_select_bit = 3;
  localparam int clock_out_source_lsb = 4;
  localparam int clock_out_source_msb = 5;
  localparam int clock_out_tristate_bit = 6;
  localparam int source_select_bit = 7;
  localparam int pll_multiplier_lsb = 8;
  localparam int pll_multiplier_msb = 18;
  localparam int lock_wait_count_lsb = 24;
  localparam int lock_wait_count_msb = 31;

  // ==========================================================
  // Field codes
  localparam logic [2:0] divider_bypass = 3'h0;
  localparam logic [2:0] divider_reserved = 3'h7;
  localparam logic [1:0] out_slow = 2'h0;
  localparam logic [1:0] out_master = 2'h1;
  localparam logic [1:0] out_master_inv = 2'h2;
  localparam logic [1:0] out_master_half = 2'h3;
  localparam logic [10:0] multiplier_off = 11'h000;
  localparam logic [7:0] lock_timer_done = 8'h01;
  localparam logic [7:0] lock_timer_one = 8'h01;

  // ==========================================================
  // Bus transfer codes
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] hresp_okay = 2'h0;

  // Bus data phase tracker
  typedef enum logic [1:0] {
    phase_idle,
    phase_write,
    phase_read_wait,
    phase_read_done
  } bus_phase_type;

endpackage

//--- verilog/power_clock_manager_regs.sv
// Contract
// - writing one disables processor clock
// - system status bit shows clock running
// - enable writes start peripheral clocks
// - disable writes stop peripheral clocks
// - peripheral status shows running clocks
// - prescaler bypass or divide 2..64
// - range bit picks low/high PLL
// - range bit takes first write only
// - output source picks slow/master/inverted/half
// - tristate bit floats the clock output
// - source select picks slow or PLL
// - zero multiplier disables the PLL
// - lock count sets slow-clock wait
// - lock status shows stable PLL
// - irq enable write unmasks lock interrupt
// - irq disable write masks lock interrupt
// - multiplier change clears lock, loads timer
// - unlocked PLL path delivers slow clock
// - lock timer is 8-bit down counter
// - processor clock on at reset, wakes
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module power_clock_manager_regs (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Clock sources and wake interrupt
  input wire logic slow_clock,
  input wire logic pll_tick,
  input wire logic enabled_irq,
  // Clock gates
  output logic cpu_clock_enable,
  output logic serial_port0_clock,
  output logic serial_port1_clock,
  output logic sync_serial_a_clock,
  output logic sync_serial_b_clock,
  output logic [5:0] timer_ch_clock,
  output logic io_port_a_clock,
  output logic io_port_b_clock,
  // PLL control
  output logic pll_enable,
  output logic [10:0] pll_multiplier,
  output logic pll_range_select,
  output logic pll_bypass,
  output logic pll_lock_irq,
  // Master clock and output pin
  output logic master_clock,
  output logic clock_out_pin,
  output logic clock_out_pin_oe
);

  // ==========================================================
  // Bus slave
  clock_manager_pkg::bus_phase_type phase; // Data phase tracker
  logic [7:0] addr_q; // Latched address
  logic wr_en; // Write data phase this cycle
  logic [31:0] read_mux; // Read value

  // Register state
  logic cpu_on; // Processor clock running
  logic [15:0] periph_on; // Peripheral clocks running
  logic [2:0] divider_select;
  logic range_bit;
  logic range_written; // First write seen
  logic [1:0] clock_out_source;
  logic clock_out_tristate;
  logic source_select;
  logic [7:0] lock_wait_count;
  logic lock; // PLL stable
  logic irq_mask; // Lock interrupt unmasked
  logic [7:0] lock_timer; // Lock down counter
  logic timer_run; // Lock countdown active

  // Clock sampling
  logic slow_s1, slow_s2, slow_s3; // Slow clock synchroniser
  logic slow_level; // Filtered slow clock
  logic slow_rise; // Slow clock rising edge
  logic pll_level; // PLL clock rebuilt from ticks
  logic src_level; // Selected source clock
  logic src_prev; // Source level last cycle
  logic [5:0] div_count; // Prescaler counter
  logic master_prev; // Master level last cycle
  logic master_half; // Master clock halved

  // Write helper: address decode of a write data phase
  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [7:0] off);
    wr_hit = en && (a == off);
  endfunction

  // Mode register field view
  function automatic logic [31:0] mode_word(
    input logic [2:0] dsel, input logic rsel, input logic [1:0] osrc,
    input logic otri, input logic ssel, input logic [10:0] mul,
    input logic [7:0] cnt);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[clock_manager_pkg::divider_select_msb:
      clock_manager_pkg::divider_select_lsb] = dsel;
    w[clock_manager_pkg::pll_range_select_bit] = rsel;
    w[clock_manager_pkg::clock_out_source_msb:
      clock_manager_pkg::clock_out_source_lsb] = osrc;
    w[clock_manager_pkg::clock_out_tristate_bit] = otri;
    w[clock_manager_pkg::source_select_bit] = ssel;
    w[clock_manager_pkg::pll_multiplier_msb:
      clock_manager_pkg::pll_multiplier_lsb] = mul;
    w[clock_manager_pkg::lock_wait_count_msb:
      clock_manager_pkg::lock_wait_count_lsb] = cnt;
    mode_word = w;
  endfunction

  // Decoded write fields
  logic [10:0] wr_mul;
  assign wr_mul = hwdata[clock_manager_pkg::pll_multiplier_msb:
                         clock_manager_pkg::pll_multiplier_lsb];
  logic mode_wr;
  assign mode_wr = wr_hit(wr_en, addr_q,
                          clock_manager_pkg::off_clock_generator_mode);
  logic mul_change; // Multiplier write with a new value
  assign mul_change = mode_wr && (wr_mul != pll_multiplier);

  assign wr_en = (phase == clock_manager_pkg::phase_write);
  assign hresp = clock_manager_pkg::hresp_okay;
  // Reads take one wait state; writes none
  assign hreadyout = (phase != clock_manager_pkg::phase_read_wait);

  // Address phase capture and data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= clock_manager_pkg::phase_idle;
      addr_q <= 8'h00;
    end else if (phase == clock_manager_pkg::phase_read_wait) begin
      phase <= clock_manager_pkg::phase_read_done;
    end else if (hsel && hready &&
                 htrans == clock_manager_pkg::htrans_nonseq) begin
      // New single transfer accepted
      addr_q <= haddr[clock_manager_pkg::addr_width-1:0];
      phase <= hwrite ? clock_manager_pkg::phase_write
                      : clock_manager_pkg::phase_read_wait;
    end else begin
      phase <= clock_manager_pkg::phase_idle;
    end
  end

  // Read value; unmapped and write-only offsets read zero
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (addr_q)
      clock_manager_pkg::off_system_clock_status: begin
        read_mux[clock_manager_pkg::cpu_bit] = cpu_on;
      end
      clock_manager_pkg::off_periph_clock_status: begin
        read_mux[15:0] = periph_on;
      end
      clock_manager_pkg::off_clock_generator_mode: begin
        read_mux = mode_word(divider_select, range_bit, clock_out_source,
                             clock_out_tristate, source_select,
                             pll_multiplier, lock_wait_count);
      end
      clock_manager_pkg::off_pll_lock_status: begin
        read_mux[clock_manager_pkg::lock_bit] = lock;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end
  // Read data captured in the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (phase == clock_manager_pkg::phase_read_wait) begin
      hrdata <= read_mux;
    end
  end

  // ==========================================================
  // Processor clock
  // Wake by interrupt wins over a disable in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_on <= clock_manager_pkg::system_clock_status_reset[
                  clock_manager_pkg::cpu_bit];
    end else if (enabled_irq) begin
      cpu_on <= 1'b1;
    end else if (wr_hit(wr_en, addr_q,
                        clock_manager_pkg::off_system_clock_disable) &&
                 hwdata[clock_manager_pkg::cpu_bit]) begin
      cpu_on <= 1'b0;
    end
  end
  assign cpu_clock_enable = cpu_on;

  // ==========================================================
  // Peripheral clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_on <= clock_manager_pkg::periph_clock_status_reset[15:0];
    end else if (wr_hit(wr_en, addr_q,
                        clock_manager_pkg::off_periph_clock_enable)) begin
      periph_on <= periph_on |
                   (hwdata[15:0] & clock_manager_pkg::periph_valid_mask);
    end else if (wr_hit(wr_en, addr_q,
                        clock_manager_pkg::off_periph_clock_disable)) begin
      periph_on <= periph_on &
                   ~(hwdata[15:0] & clock_manager_pkg::periph_valid_mask);
    end
  end
  assign serial_port0_clock = periph_on[clock_manager_pkg::serial_port0_bit];
  assign serial_port1_clock = periph_on[clock_manager_pkg::serial_port1_bit];
  assign sync_serial_a_clock = periph_on[clock_manager_pkg::sync_serial_a_bit];
  assign sync_serial_b_clock = periph_on[clock_manager_pkg::sync_serial_b_bit];
  assign timer_ch_clock = periph_on[clock_manager_pkg::timer_ch5_bit:
                                    clock_manager_pkg::timer_ch0_bit];
  assign io_port_a_clock = periph_on[clock_manager_pkg::io_port_a_bit];
  assign io_port_b_clock = periph_on[clock_manager_pkg::io_port_b_bit];

  // ==========================================================
  // Clock generator mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      divider_select <= clock_manager_pkg::clock_generator_mode_reset[2:0];
      clock_out_source <= clock_manager_pkg::out_slow;
      clock_out_tristate <= 1'b0;
      source_select <= 1'b0;
      pll_multiplier <= clock_manager_pkg::multiplier_off;
      lock_wait_count <= 8'h00;
    end else if (mode_wr) begin
      divider_select <= hwdata[clock_manager_pkg::divider_select_msb:
                               clock_manager_pkg::divider_select_lsb];
      clock_out_source <= hwdata[clock_manager_pkg::clock_out_source_msb:
                                 clock_manager_pkg::clock_out_source_lsb];
      clock_out_tristate <= hwdata[clock_manager_pkg::clock_out_tristate_bit];
      source_select <= hwdata[clock_manager_pkg::source_select_bit];
      pll_multiplier <= wr_mul;
      lock_wait_count <= hwdata[clock_manager_pkg::lock_wait_count_msb:
                                clock_manager_pkg::lock_wait_count_lsb];
    end
  end

  // Range bit: only the first write after reset sticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_bit <= 1'b0;
      range_written <= 1'b0;
    end else if (mode_wr && !range_written) begin
      range_bit <= hwdata[clock_manager_pkg::pll_range_select_bit];
      range_written <= 1'b1;
    end
  end
  assign pll_range_select = range_bit;
  assign pll_enable = (pll_multiplier != clock_manager_pkg::multiplier_off);

  // ==========================================================
  // Slow clock sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_s3 <= 1'b0;
    end else begin
      slow_s1 <= slow_clock;
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
    end
  end
  // Level moves once the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_level <= 1'b0;
    end else if (slow_s2 == slow_s3) begin
      slow_level <= slow_s3;
    end
  end
  assign slow_rise = (slow_s2 == slow_s3) && slow_s3 && !slow_level;

  // ==========================================================
  // PLL lock timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_timer <= 8'h00;
      timer_run <= 1'b0;
      lock <= 1'b0;
    end else if (mul_change) begin
      // New multiplier: restart countdown unless PLL is off
      lock_timer <= hwdata[clock_manager_pkg::lock_wait_count_msb:
                           clock_manager_pkg::lock_wait_count_lsb];
      timer_run <= (wr_mul != clock_manager_pkg::multiplier_off);
      lock <= 1'b0;
    end else if (timer_run && slow_rise) begin
      // Count down on slow clock edges
      if (lock_timer <= clock_manager_pkg::lock_timer_done) begin
        lock_timer <= 8'h00;
        timer_run <= 1'b0;
        lock <= 1'b1;
      end else begin
        lock_timer <= lock_timer - clock_manager_pkg::lock_timer_one;
      end
    end
  end
  assign pll_bypass = !lock;

  // ==========================================================
  // Lock interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= 1'b0;
    end else if (wr_hit(wr_en, addr_q, clock_manager_pkg::off_pll_irq_enable)
                 && hwdata[clock_manager_pkg::lock_bit]) begin
      irq_mask <= 1'b1;
    end else if (wr_hit(wr_en, addr_q,
                        clock_manager_pkg::off_pll_irq_disable) &&
                 hwdata[clock_manager_pkg::lock_bit]) begin
      irq_mask <= 1'b0;
    end
  end
  assign pll_lock_irq = lock && irq_mask;

  // ==========================================================
  // Source clock and prescaler
  // PLL output rebuilt as a level from its tick pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_level <= 1'b0;
    end else if (pll_tick) begin
      pll_level <= !pll_level;
    end
  end
  // Unlocked PLL path falls back to the slow clock
  assign src_level = (source_select && lock) ? pll_level : slow_level;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev <= 1'b0;
      div_count <= 6'h00;
    end else begin
      src_prev <= src_level;
      if (src_level && !src_prev) begin
        div_count <= div_count + 6'h01;
      end
    end
  end

  // Master clock: bypass, or a counter bit for divide by 2^code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_clock <= 1'b0;
    end else if (divider_select == clock_manager_pkg::divider_bypass ||
                 divider_select == clock_manager_pkg::divider_reserved) begin
      master_clock <= src_level;
    end else begin
      master_clock <= div_count[divider_select - 3'h1];
    end
  end
  // Master clock halved for the output pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_prev <= 1'b0;
      master_half <= 1'b0;
    end else begin
      master_prev <= master_clock;
      if (master_clock && !master_prev) begin
        master_half <= !master_half;
      end
    end
  end

  // ==========================================================
  // Clock output pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_out_pin <= 1'b0;
    end else begin
      unique case (clock_out_source)
        clock_manager_pkg::out_slow: clock_out_pin <= slow_level;
        clock_manager_pkg::out_master: clock_out_pin <= master_clock;
        clock_manager_pkg::out_master_inv: clock_out_pin <= !master_clock;
        clock_manager_pkg::out_master_half: clock_out_pin <= master_half;
      endcase
    end
  end
  assign clock_out_pin_oe = !clock_out_tristate;

endmodule

`default_nettype wire
